// ===== inc/sarseq_map.vh
`ifndef SARSEQ_MAP_VH
`define SARSEQ_MAP_VH
// word offsets on the avalon bus (byte address = 4 * index)
`define SARSEQ_IDX_CTRL 2'h0
`define SARSEQ_IDX_CONF 2'h1
`define SARSEQ_IDX_RESH 2'h2
`define SARSEQ_IDX_RESL 2'h3
`define SARSEQ_IDX_MODE 3'h4
// control_status field positions
`define SARSEQ_C_START 0
`define SARSEQ_C_REFSW 1
`define SARSEQ_C_BUSY 2
`define SARSEQ_C_DONE 3
`define SARSEQ_C_CHLO 4
`define SARSEQ_C_CHHI 7
// configuration field positions
`define SARSEQ_G_DIVLO 0
`define SARSEQ_G_DIVHI 1
`define SARSEQ_G_CONT 2
`define SARSEQ_G_IE 3
`define SARSEQ_G_TRIG 4
`define SARSEQ_G_STLO 5
`define SARSEQ_G_STHI 6
`define SARSEQ_G_EIGHT 7
// power mode register: bit0 stop, bit1 watch
`define SARSEQ_M_STOP 0
`define SARSEQ_M_WATCH 1
// sampling counts in conversion clocks
`define SARSEQ_SAMP0 5'h04
`define SARSEQ_SAMP1 5'h07
`define SARSEQ_SAMP2 5'h0A
`define SARSEQ_SAMP3 5'h10
// compare phase length in conversion clocks
`define SARSEQ_CMP_BITS 4'hA
// first trial code of the successive approximation
`define SARSEQ_MSB 10'h200
// interrupt identification
`define SARSEQ_IRQ_NUM 8'h12
`define SARSEQ_VEC_HI 16'hFFD6
`define SARSEQ_VEC_LO 16'hFFD7
`endif

// ===== hdl/sarseq_top.v
`timescale 1ns/1ps
`include "sarseq_map.vh"

// Notes on behaviour
// - completion flag set on every conversion end
// - request raised when flag and enable high
// - flag sets regardless of enable
// - writing zero clears flag and request
// - request number 18, vector FFD6/FFD7
// - start bit starts or restarts conversion, ignored in continuous mode
// - continuous mode starts on trigger rising edge
// - start sets busy, connects selected channel
// - sample window then hold until done
// - resolve MSB to LSB, then load result
// - after load, busy cleared, flag set
// - result registers keep old value meanwhile
// - reset, stop or watch halts, clears busy
// - restart coinciding with completion still sets flag
// - sampling equals conversion clock times selected count
// - startup between two and one-plus-divided clocks
// - start jitter up to one conversion clock
// - sample counts 4, 7, 10, 16
// - conversion clock divides by 1, 2, 4, 8
// - 10-bit split high/low, 8-bit high reads zero
// - trigger select chooses pin or timer output
module sarseq_top (
  input wire sys_clk,
  input wire srst,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire trigger_input_pin,
  input wire composite_timer_output,
  input wire cmp_greater,
  output wire irq_req,
  output wire [7:0] irq_number,
  output wire [3:0] channel_sel_out,
  output wire chan_connect,
  output wire sample_en,
  output wire [9:0] dac_code,
  output wire ref_switch_on,
  output wire busy_out
);
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_SAMP = 3'h2;
  localparam ST_CMP = 3'h3;
  localparam ST_TAIL = 3'h4;
  localparam ST_LOAD = 3'h5;

  reg [7:0] conf_reg;
  reg [3:0] chan_reg;
  reg refsw_reg;
  reg done_reg;
  reg busy_reg;
  reg [1:0] mode_reg;
  reg [9:0] result_reg;
  reg [9:0] sar_reg;
  reg [9:0] trial_reg;
  reg [2:0] state_reg;
  reg [4:0] cnt_reg;
  reg [2:0] div_reg;
  reg irq_reg;
  reg sample_reg;
  reg conn_reg;
  reg [31:0] rdata_reg;
  reg ack_reg;
  reg trig_s1_reg;
  reg trig_s2_reg;
  reg trig_prev_reg;
  reg [7:0] irqn_reg;
  reg [9:0] dac_reg;
  reg wait_reg;

  wire wr_ok = avs_write && !ack_reg && avs_byteenable[0];
  wire wr_ctrl = wr_ok && (avs_address == {1'b0, `SARSEQ_IDX_CTRL});
  wire wr_conf = wr_ok && (avs_address == {1'b0, `SARSEQ_IDX_CONF});
  wire wr_mode = wr_ok && (avs_address == `SARSEQ_IDX_MODE);
  wire halt = mode_reg[`SARSEQ_M_STOP] || mode_reg[`SARSEQ_M_WATCH];
  wire cont = conf_reg[`SARSEQ_G_CONT];

  // conversion clock tick from divider
  reg ck_tick;
  always @* begin
    case (conf_reg[`SARSEQ_G_DIVHI:`SARSEQ_G_DIVLO])
      2'h0: ck_tick = 1'b1;
      2'h1: ck_tick = (div_reg[0] == 1'b1);
      2'h2: ck_tick = (div_reg[1:0] == 2'h3);
      default: ck_tick = (div_reg == 3'h7);
    endcase
  end

  reg [4:0] samp_cnt;
  always @* begin
    case (conf_reg[`SARSEQ_G_STHI:`SARSEQ_G_STLO])
      2'h0: samp_cnt = `SARSEQ_SAMP0;
      2'h1: samp_cnt = `SARSEQ_SAMP1;
      2'h2: samp_cnt = `SARSEQ_SAMP2;
      default: samp_cnt = `SARSEQ_SAMP3;
    endcase
  end

  // selected trigger synchronised, then edge-detected
  wire trig_sel = conf_reg[`SARSEQ_G_TRIG] ? composite_timer_output : trigger_input_pin;
  wire trig_edge = trig_s2_reg && !trig_prev_reg;
  wire sw_start = wr_ctrl && avs_writedata[`SARSEQ_C_START] && !cont;
  wire hw_start = cont && trig_edge;
  wire start = (sw_start || hw_start) && !halt;
  wire finish = (state_reg == ST_LOAD);
  wire eight = conf_reg[`SARSEQ_G_EIGHT];
  // 8-bit mode resolves the same top bits and drops the two lowest at load
  wire [9:0] msb_bit = `SARSEQ_MSB;
  wire [9:0] sar_next = cmp_greater ? (sar_reg | trial_reg) : sar_reg;
  wire [9:0] trial_next = {1'b0, trial_reg[9:1]};

  always @(posedge sys_clk) begin
    if (srst) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_s1_reg <= trig_sel;
      trig_s2_reg <= trig_s1_reg;
      trig_prev_reg <= trig_s2_reg;
    end
  end

  // register file and flags
  always @(posedge sys_clk) begin
    if (srst) begin
      conf_reg <= 8'h00;
      chan_reg <= 4'h0;
      refsw_reg <= 1'b0;
      done_reg <= 1'b0;
      mode_reg <= 2'h0;
      irq_reg <= 1'b0;
      irqn_reg <= 8'h00;
    end else begin
      irqn_reg <= `SARSEQ_IRQ_NUM;
      if (wr_conf) begin
        conf_reg <= avs_writedata[7:0];
      end
      if (wr_mode) begin
        mode_reg <= avs_writedata[1:0];
      end
      if (wr_ctrl) begin
        chan_reg <= avs_writedata[`SARSEQ_C_CHHI:`SARSEQ_C_CHLO];
        refsw_reg <= avs_writedata[`SARSEQ_C_REFSW];
      end
      if (finish) begin
        done_reg <= 1'b1;
      end else if (wr_ctrl && !avs_writedata[`SARSEQ_C_DONE]) begin
        done_reg <= 1'b0;
      end
      irq_reg <= (finish || (done_reg && !(wr_ctrl && !avs_writedata[`SARSEQ_C_DONE])))
                 && (wr_conf ? avs_writedata[`SARSEQ_G_IE] : conf_reg[`SARSEQ_G_IE]);
    end
  end

  // conversion sequencer
  always @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      cnt_reg <= 5'h00;
      div_reg <= 3'h0;
      sar_reg <= 10'h000;
      trial_reg <= 10'h000;
      dac_reg <= 10'h000;
      result_reg <= 10'h000;
      sample_reg <= 1'b0;
      conn_reg <= 1'b0;
    end else if (halt) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      sample_reg <= 1'b0;
      conn_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      if (start) begin
        state_reg <= ST_START;
        busy_reg <= 1'b1;
        conn_reg <= 1'b1;
        sample_reg <= 1'b0;
        cnt_reg <= 5'h00;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            busy_reg <= 1'b0;
          end
          ST_START: begin
            if (ck_tick) begin
              state_reg <= ST_SAMP;
              sample_reg <= 1'b1;
              cnt_reg <= samp_cnt - 5'h01;
            end
          end
          ST_SAMP: begin
            if (ck_tick) begin
              if (cnt_reg == 5'h00) begin
                state_reg <= ST_CMP;
                sample_reg <= 1'b0;
                sar_reg <= 10'h000;
                trial_reg <= msb_bit;
                dac_reg <= msb_bit;
                cnt_reg <= {1'b0, `SARSEQ_CMP_BITS} - 5'h01;
              end else begin
                cnt_reg <= cnt_reg - 5'h01;
              end
            end
          end
          ST_CMP: begin
            if (ck_tick) begin
              sar_reg <= sar_next;
              trial_reg <= trial_next;
              // trial code kept registered so the comparator sees a settled level
              dac_reg <= sar_next | trial_next;
              if (cnt_reg == 5'h00) begin
                state_reg <= ST_TAIL;
              end else begin
                cnt_reg <= cnt_reg - 5'h01;
              end
            end
          end
          ST_TAIL: begin
            state_reg <= ST_LOAD;
            conn_reg <= 1'b0;
            result_reg <= eight ? {2'h0, sar_reg[9:2]} : sar_reg;
          end
          ST_LOAD: begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // avalon slave: one wait cycle, answer on second
  always @(posedge sys_clk) begin
    if (srst) begin
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      // registered copy of the inverted acknowledge
      wait_reg <= !((avs_read || avs_write) && !ack_reg);
      if (avs_read && !ack_reg) begin
        case (avs_address)
          {1'b0, `SARSEQ_IDX_CTRL}: rdata_reg <= {24'h000000, chan_reg, done_reg, busy_reg,
                                                  refsw_reg, 1'b0};
          {1'b0, `SARSEQ_IDX_CONF}: rdata_reg <= {24'h000000, conf_reg};
          {1'b0, `SARSEQ_IDX_RESH}: rdata_reg <= {30'h00000000, result_reg[9:8]};
          {1'b0, `SARSEQ_IDX_RESL}: rdata_reg <= {24'h000000, result_reg[7:0]};
          `SARSEQ_IDX_MODE: rdata_reg <= {30'h00000000, mode_reg};
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign irq_req = irq_reg;
  assign irq_number = irqn_reg;
  assign channel_sel_out = chan_reg;
  assign chan_connect = conn_reg;
  assign sample_en = sample_reg;
  assign dac_code = dac_reg;
  assign ref_switch_on = refsw_reg;
  assign busy_out = busy_reg;
endmodule // sarseq_top

// ===== testbench/sarseq_top_asserts.sv
`timescale 1ns/1ps
module sarseq_top_asserts (
  input wire sys_clk,
  input wire srst,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  input wire [7:0] irq_number,
  input wire chan_connect,
  input wire sample_en,
  input wire busy_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_irq_num; !$past(srst) |-> irq_number == 8'h12; endproperty
  a_irq_num: assert property (p_irq_num) else $error("irq number wrong");
  property p_take; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_take: assert property (p_take) else $error("no answer after one wait state");
  property p_idle; !(avs_read || avs_write) |-> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest low while idle");
  property p_busy_con; $rose(busy_out) |-> chan_connect; endproperty
  a_busy_con: assert property (p_busy_con) else $error("busy without channel");
  property p_smp_con; sample_en |-> busy_out && chan_connect; endproperty
  a_smp_con: assert property (p_smp_con) else $error("sampling outside conversion");
  property p_smp_len; $rose(sample_en) |-> sample_en [*4]; endproperty
  a_smp_len: assert property (p_smp_len) else $error("sampling too short");
  property p_cmp_len; $fell(sample_en) && busy_out |-> !sample_en [*8]; endproperty
  a_cmp_len: assert property (p_cmp_len) else $error("compare phase too short");
  property p_halt;
    avs_write && avs_waitrequest && avs_address == 3'h4 && avs_byteenable[0]
      && avs_writedata[1:0] != 2'h0 |=> ##[0:1] !busy_out;
  endproperty
  a_halt: assert property (p_halt) else $error("busy kept after halt");
endmodule // sarseq_top_asserts

// ===== testbench/sarseq_ana_model.sv
`timescale 1ns/1ps
module sarseq_ana_model (
  input wire sys_clk,
  input wire sample_en,
  input wire [9:0] level,
  input wire [9:0] dac_code,
  output wire cmp_greater
);
  reg [9:0] held_reg;
  // capacitor tracks the input only while sampling, then holds
  always @(posedge sys_clk) begin
    if (sample_en) held_reg <= level;
  end
  assign cmp_greater = (held_reg >= dac_code);
endmodule // sarseq_ana_model

// ===== testbench/tb_sarseq_top.sv
`timescale 1ns/1ps
module tb_sarseq_top;
  reg sys_clk, srst, rd, wr, trg, tmr;
  reg [2:0] adr;
  reg [31:0] wd, q, old;
  reg [3:0] be;
  reg [9:0] lvl;
  wire [31:0] rdata;
  wire wreq, cmp, irq, con, smp, refo, busy;
  wire [7:0] irqn;
  wire [3:0] chs;
  wire [9:0] dac;
  integer bad_count, checked, n, k;
  sarseq_top u_dut (.sys_clk(sys_clk), .srst(srst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .trigger_input_pin(trg), .composite_timer_output(tmr),
    .cmp_greater(cmp), .irq_req(irq), .irq_number(irqn), .channel_sel_out(chs),
    .chan_connect(con), .sample_en(smp), .dac_code(dac), .ref_switch_on(refo), .busy_out(busy));
  sarseq_ana_model u_ana (.sys_clk(sys_clk), .sample_en(smp), .level(lvl), .dac_code(dac),
    .cmp_greater(cmp));
  task give_verdict; begin
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g); begin
    checked = checked + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("unexpected %0s expected %h seen %h", nm, e, g);
    end
  end endtask
  task bus(input w, input [2:0] a, input [7:0] d); integer t; begin
    @(posedge sys_clk);
    adr <= a; wr <= w; rd <= !w; wd <= {24'h0, d};
    t = 0;
    @(posedge sys_clk);
    while (wreq !== 1'b0 && t < 50) begin t = t + 1; @(posedge sys_clk); end
    if (t == 50) bad_count = bad_count + 1;
    q = rdata; wr <= 1'b0; rd <= 1'b0;
  end endtask
  task wdone; integer t; begin
    t = 0; n = 0;
    while (busy !== 1'b0 && t < 3000) begin
      @(posedge sys_clk); t = t + 1;
      if (smp === 1'b1) n = n + 1;
    end
    if (t == 3000) bad_count = bad_count + 1;
  end endtask
  task s_reset; begin
    for (k = 0; k < 6; k = k + 1) if (k != 4) begin bus(0, k, 0); chk("reg", 0, q); end
    chk("irqn", 8'h12, irqn);
    chk("refsw", 0, refo);
    chk("chan", 0, chs);
  end endtask
  task s_timing; begin
    for (k = 0; k < 4; k = k + 1) begin
      lvl <= 10'h2A5 ^ k;
      bus(1, 1, (k << 5) | k);
      bus(1, 0, 8'h09);
      wdone;
      chk("samp", (k == 0 ? 4 : k == 1 ? 7 : k == 2 ? 10 : 16) << k, n);
      bus(0, 2, 0); chk("res_high", (10'h2A5 ^ k) >> 8, q);
      bus(0, 3, 0); chk("res_low", (10'h2A5 ^ k) & 8'hFF, q);
      bus(0, 0, 0); chk("ctrl", 8'h08, q);
      chk("irq", 0, irq);
    end
  end endtask
  task s_irq; begin
    bus(1, 1, 8'h08); bus(1, 0, 8'h09); wdone;
    repeat (2) @(posedge sys_clk);
    chk("irq", 1, irq);
    bus(1, 0, 8'h00); repeat (2) @(posedge sys_clk);
    chk("irq", 0, irq);
    bus(0, 0, 0); chk("done", 0, q[3]);
    bus(0, 3, 0); chk("res_low", 8'hA6, q);
  end endtask
  task s_eight; begin
    lvl <= 10'h3C7; bus(1, 1, 8'h80); bus(1, 0, 8'h09); wdone;
    bus(0, 2, 0); chk("res_high", 0, q);
    bus(0, 3, 0); chk("res_low", 8'hF1, q);
  end endtask
  task s_restart; begin
    bus(1, 1, 8'h03); bus(0, 3, 0); old = q;
    lvl <= 10'h1E6; bus(1, 0, 8'h09);
    repeat (70) @(posedge sys_clk);
    bus(0, 3, 0); chk("res_keep", old, q);
    bus(1, 0, 8'h09); lvl <= 10'h0B3; chk("busy", 1, busy);
    while (smp !== 1'b1) @(posedge sys_clk);
    while (smp !== 1'b0) @(posedge sys_clk);
    lvl <= 10'h3FF; wdone;
    bus(0, 3, 0); chk("res_new", 8'hB3, q);
  end endtask
  task pulse(input p, input [31:0] e); begin
    @(posedge sys_clk);
    if (p) tmr <= 1'b1; else trg <= 1'b1;
    n = 0;
    repeat (8) begin @(posedge sys_clk); if (busy === 1'b1) n = 1; end
    chk("trig", e, n);
    trg <= 1'b0; tmr <= 1'b0; wdone;
  end endtask
  task s_cont; begin
    bus(1, 1, 8'h04); pulse(0, 1); pulse(1, 0);
    bus(1, 1, 8'h14); pulse(1, 1); pulse(0, 0);
    bus(1, 1, 8'h00); pulse(1, 0); pulse(0, 0);
  end endtask
  task s_halt; begin
    for (k = 1; k < 3; k = k + 1) begin
      bus(1, 1, 8'h03); bus(1, 0, 8'h5B);
      chk("chan", 5, chs);
      chk("refsw", 1, refo);
      repeat (20) @(posedge sys_clk);
      bus(1, 4, k); repeat (2) @(posedge sys_clk);
      chk("busy", 0, busy);
      bus(1, 4, 0);
    end
  end endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #900000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    bad_count = 0; checked = 0; srst = 1'b1; rd = 1'b0; wr = 1'b0; trg = 1'b0; tmr = 1'b0;
    adr = 3'h0; wd = 32'h0; be = 4'hF; lvl = 10'h000;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    s_reset; s_timing; s_irq; s_eight; s_restart; s_cont; s_halt;
    give_verdict;
  end
endmodule // tb_sarseq_top
bind sarseq_top sarseq_top_asserts u_chk (.sys_clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .irq_number,
  .chan_connect, .sample_en, .busy_out);
